// >>> rtl/ceil_div.sv
`timescale 1ns/1ps
module ceil_div (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // request
  input wire logic start_i,
  input wire logic [23:0] num_i,
  input wire logic [13:0] den_i,
  // answer
  output logic busy_o,
  output logic done_o,
  output logic [23:0] quot_o
);
  logic [23:0] num_ff;
  logic [23:0] quo_ff;
  logic [14:0] rem_ff;
  logic [13:0] den_ff;
  logic [4:0] cnt_ff;
  logic [14:0] trial;

  assign trial = {rem_ff[13:0], num_ff[23]};

  // restoring division, one quotient bit per cycle; rounds up at the end
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      quot_o <= 24'h00_0000;
      num_ff <= 24'h00_0000;
      quo_ff <= 24'h00_0000;
      rem_ff <= 15'h0000;
      den_ff <= 14'h0000;
      cnt_ff <= 5'h00;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        busy_o <= 1'b1;
        num_ff <= num_i;
        den_ff <= den_i;
        quo_ff <= 24'h00_0000;
        rem_ff <= 15'h0000;
        cnt_ff <= 5'h00;
      end else if (busy_o) begin
        num_ff <= {num_ff[22:0], 1'b0};
        if (trial >= {1'b0, den_ff}) begin
          rem_ff <= trial - {1'b0, den_ff};
          quo_ff <= {quo_ff[22:0], 1'b1};
        end else begin
          rem_ff <= trial;
          quo_ff <= {quo_ff[22:0], 1'b0};
        end
        cnt_ff <= cnt_ff + 5'h01;
        if (cnt_ff == 5'h18) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          quot_o <= quo_ff + {23'h00_0000, (rem_ff != 15'h0000)};
          num_ff <= num_ff;
          rem_ff <= rem_ff;
          quo_ff <= quo_ff;
        end
      end
    end
  end
endmodule

// >>> rtl/frame_limit_pkg.sv
package frame_limit_pkg;

  // clock and time base
  localparam int CLK_PERIOD_NS = 5;
  localparam int CYC_PER_US = 1000 / CLK_PERIOD_NS;
  localparam logic [31:0] T_LINE_US = 32'h0000_001F;      // 31 us per line
  localparam logic [31:0] T_FIXED_US = 32'h0000_018D;     // 397 us fixed
  localparam logic [31:0] T_BUS_CYCLE_US = 32'h0000_007D; // 125 us

  // payload size limits and reset value
  localparam logic [13:0] BPP_MIN = 14'h0004;
  localparam logic [13:0] BPP_MAX = 14'h2000;
  localparam logic [13:0] BPP_RST = BPP_MAX;

  // frame buffer
  localparam int BUF_DEPTH = 4096;
  localparam int BUF_AW = 12;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_EXPOSURE = 8'h04;
  localparam logic [7:0] REG_AOI_HEIGHT = 8'h08;
  localparam logic [7:0] REG_AOI_WIDTH = 8'h0C;
  localparam logic [7:0] REG_PKT_SIZE = 8'h10;
  localparam logic [7:0] REG_PKT_PER_FRAME = 8'h14;
  localparam logic [7:0] REG_MIN_PERIOD = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;

  // reset values
  localparam logic [23:0] EXPOSURE_RST = 24'h00_03E8;
  localparam logic [11:0] AOI_HEIGHT_RST = 12'h040;
  localparam logic [11:0] AOI_WIDTH_RST = 12'h040;

  // colour tags
  localparam logic [1:0] COLOR_RED = 2'h0;
  localparam logic [1:0] COLOR_GREEN = 2'h1;
  localparam logic [1:0] COLOR_BLUE = 2'h2;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } pix_beat_t;

  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic [1:0] color;
    logic [7:0] data;
  } pkt_beat_t;

  typedef enum logic [1:0] {BUF_EMPTY, BUF_FILL, BUF_FULL} buf_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} tx_state_t;

endpackage

// >>> rtl/frame_rate_limit_packetizer.sv
`timescale 1ns/1ps
module frame_rate_limit_packetizer (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // capture control
  input wire logic capture_req_i,
  output logic capture_start_o,
  // sensor pixel stream
  input wire frame_limit_pkg::pix_beat_t pix_i,
  // bus packet stream
  output frame_limit_pkg::pkt_beat_t pkt_o
);
  import frame_limit_pkg::*;

  logic enable_ff;
  logic [23:0] exposure_ff;
  logic [11:0] height_ff;
  logic [11:0] width_ff;
  logic [13:0] bpp_ff;
  logic [23:0] ppf_ff;
  logic dirty_ff;
  logic div_busy;
  logic div_done;
  logic [23:0] div_quot;
  logic [31:0] exp_period_ff;
  logic [31:0] xfer_period_ff;
  logic [31:0] limit_ff;
  logic [7:0] us_cnt_ff;
  logic us_tick_ff;
  logic [6:0] cyc_cnt_ff;
  logic cyc_tick_ff;
  logic [31:0] since_ff;
  logic pending_ff;
  buf_state_t buf_ff;
  tx_state_t tx_ff;
  logic [9:0] mem [BUF_DEPTH];
  logic [12:0] wr_cnt_ff;
  logic [11:0] col_ff;
  logic row_odd_ff;
  logic [23:0] tx_idx_ff;
  logic [13:0] beat_ff;
  logic [23:0] pkt_cnt_ff;
  logic [13:0] tx_bpp_ff;
  logic [23:0] tx_ppf_ff;
  logic wr_hit;
  logic elapsed;
  logic can_start;
  logic [1:0] pix_color;
  logic [13:0] bpp_clamped;

  assign wr_hit = reg_wr_i;
  assign elapsed = since_ff >= limit_ff;
  assign can_start = enable_ff && pending_ff && elapsed
                     && buf_ff == BUF_EMPTY && !dirty_ff && !div_busy;

  // software may ask for any size; out-of-range values are pinned
  always_comb begin
    if (reg_wdata_i[31:0] < {18'h0_0000, BPP_MIN}) begin
      bpp_clamped = BPP_MIN;
    end else if (reg_wdata_i[31:0] > {18'h0_0000, BPP_MAX}) begin
      bpp_clamped = BPP_MAX;
    end else begin
      bpp_clamped = reg_wdata_i[13:0];
    end
  end

  // settings
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      enable_ff <= 1'b0;
      exposure_ff <= EXPOSURE_RST;
      height_ff <= AOI_HEIGHT_RST;
      width_ff <= AOI_WIDTH_RST;
      bpp_ff <= BPP_RST;
    end else if (wr_hit) begin
      case (reg_addr_i)
        REG_CTRL: enable_ff <= reg_wdata_i[0];
        REG_EXPOSURE: exposure_ff <= reg_wdata_i[23:0];
        REG_AOI_HEIGHT: height_ff <= reg_wdata_i[11:0];
        REG_AOI_WIDTH: width_ff <= reg_wdata_i[11:0];
        REG_PKT_SIZE: bpp_ff <= bpp_clamped;
        default: ;
      endcase
    end
  end

  // packets-per-frame recompute; a write in the same cycle keeps it dirty
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      dirty_ff <= 1'b1;
      ppf_ff <= 24'h00_0000;
    end else begin
      if (wr_hit && (reg_addr_i == REG_AOI_HEIGHT
          || reg_addr_i == REG_AOI_WIDTH || reg_addr_i == REG_PKT_SIZE)) begin
        dirty_ff <= 1'b1;
      end else if (!div_busy) begin
        dirty_ff <= 1'b0;
      end
      if (div_done) begin
        ppf_ff <= div_quot;
      end
    end
  end

  ceil_div u_ppf_div (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i(dirty_ff && !div_busy),
    .num_i(24'(width_ff) * 24'(height_ff)),
    .den_i(bpp_ff),
    .busy_o(div_busy),
    .done_o(div_done),
    .quot_o(div_quot)
  );

  // both limits as periods in us; longer period is the lower rate
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      exp_period_ff <= 32'h0000_0000;
      xfer_period_ff <= 32'h0000_0000;
      limit_ff <= 32'h0000_0000;
    end else begin
      exp_period_ff <= 32'(exposure_ff) + 32'(height_ff) * T_LINE_US
                       + T_FIXED_US;
      xfer_period_ff <= 32'(ppf_ff) * T_BUS_CYCLE_US;
      limit_ff <= (exp_period_ff > xfer_period_ff) ? exp_period_ff
                  : xfer_period_ff;
    end
  end

  // 1 us enable and 125 us bus cycle enable
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      us_cnt_ff <= 8'h00;
      us_tick_ff <= 1'b0;
      cyc_cnt_ff <= 7'h00;
      cyc_tick_ff <= 1'b0;
    end else begin
      us_tick_ff <= 1'b0;
      cyc_tick_ff <= 1'b0;
      if (us_cnt_ff == 8'(CYC_PER_US - 1)) begin
        us_cnt_ff <= 8'h00;
        us_tick_ff <= 1'b1;
      end else begin
        us_cnt_ff <= us_cnt_ff + 8'h01;
      end
      if (us_tick_ff) begin
        if (cyc_cnt_ff == 7'(T_BUS_CYCLE_US - 32'h0000_0001)) begin
          cyc_cnt_ff <= 7'h00;
          cyc_tick_ff <= 1'b1;
        end else begin
          cyc_cnt_ff <= cyc_cnt_ff + 7'h01;
        end
      end
    end
  end

  // capture gating: time since last start saturates rather than wraps
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      since_ff <= 32'hFFFF_FFFF;
      pending_ff <= 1'b0;
      capture_start_o <= 1'b0;
    end else begin
      capture_start_o <= can_start;
      if (can_start) begin
        since_ff <= 32'h0000_0000;
      end else if (us_tick_ff && since_ff != 32'hFFFF_FFFF) begin
        since_ff <= since_ff + 32'h0000_0001;
      end
      if (capture_req_i) begin
        pending_ff <= 1'b1;
      end else if (can_start) begin
        pending_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    if (!row_odd_ff) begin
      pix_color = col_ff[0] ? COLOR_GREEN : COLOR_BLUE;
    end else begin
      pix_color = col_ff[0] ? COLOR_RED : COLOR_GREEN;
    end
  end

  // frame buffer fill; pixels past the buffer depth are dropped
  always_ff @(posedge clk_sys_i) begin
    if (buf_ff == BUF_FILL && pix_i.valid && wr_cnt_ff < 13'(BUF_DEPTH)) begin
      mem[wr_cnt_ff[BUF_AW-1:0]] <= {pix_color, pix_i.data};
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      buf_ff <= BUF_EMPTY;
      wr_cnt_ff <= 13'h0000;
      col_ff <= 12'h000;
      row_odd_ff <= 1'b0;
    end else begin
      case (buf_ff)
        BUF_EMPTY: begin
          if (can_start) begin
            buf_ff <= BUF_FILL;
            wr_cnt_ff <= 13'h0000;
            col_ff <= 12'h000;
            row_odd_ff <= 1'b0;
          end
        end
        BUF_FILL: begin
          if (pix_i.valid) begin
            if (wr_cnt_ff < 13'(BUF_DEPTH)) begin
              wr_cnt_ff <= wr_cnt_ff + 13'h0001;
            end
            if (col_ff == width_ff - 12'h001) begin
              col_ff <= 12'h000;
              row_odd_ff <= !row_odd_ff;
            end else begin
              col_ff <= col_ff + 12'h001;
            end
            if (pix_i.last) begin
              buf_ff <= BUF_FULL;
            end
          end
        end
        BUF_FULL: begin
          if (tx_ff == TX_SEND && pkt_cnt_ff == tx_ppf_ff - 24'h00_0001
              && beat_ff == tx_bpp_ff - 14'h0001) begin
            buf_ff <= BUF_EMPTY;
          end
        end
        default: buf_ff <= BUF_EMPTY;
      endcase
    end
  end

  // packetizer: one packet of exactly bpp bytes per bus cycle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tx_ff <= TX_IDLE;
      tx_idx_ff <= 24'h00_0000;
      beat_ff <= 14'h0000;
      pkt_cnt_ff <= 24'h00_0000;
      tx_bpp_ff <= BPP_RST;
      tx_ppf_ff <= 24'h00_0000;
      pkt_o <= '0;
    end else begin
      pkt_o <= '0;
      case (tx_ff)
        TX_IDLE: begin
          if (buf_ff == BUF_FULL) begin
            tx_ff <= TX_WAIT;
            tx_idx_ff <= 24'h00_0000;
            pkt_cnt_ff <= 24'h00_0000;
            tx_bpp_ff <= bpp_ff;
            tx_ppf_ff <= ppf_ff;
          end
        end
        TX_WAIT: begin
          if (cyc_tick_ff) begin
            tx_ff <= TX_SEND;
            beat_ff <= 14'h0000;
          end
        end
        TX_SEND: begin
          pkt_o.valid <= 1'b1;
          pkt_o.sop <= beat_ff == 14'h0000;
          pkt_o.eop <= beat_ff == tx_bpp_ff - 14'h0001;
          // the tail of the last packet is padded with zero bytes
          if (tx_idx_ff < 24'(wr_cnt_ff)) begin
            {pkt_o.color, pkt_o.data} <= mem[tx_idx_ff[BUF_AW-1:0]];
          end
          tx_idx_ff <= tx_idx_ff + 24'h00_0001;
          beat_ff <= beat_ff + 14'h0001;
          if (beat_ff == tx_bpp_ff - 14'h0001) begin
            pkt_cnt_ff <= pkt_cnt_ff + 24'h00_0001;
            tx_ff <= (pkt_cnt_ff == tx_ppf_ff - 24'h00_0001) ? TX_IDLE
                     : TX_WAIT;
          end
        end
        default: tx_ff <= TX_IDLE;
      endcase
    end
  end

  // register reads, data in the following cycle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        REG_CTRL: reg_rdata_o <= {31'h0000_0000, enable_ff};
        REG_EXPOSURE: reg_rdata_o <= 32'(exposure_ff);
        REG_AOI_HEIGHT: reg_rdata_o <= 32'(height_ff);
        REG_AOI_WIDTH: reg_rdata_o <= 32'(width_ff);
        REG_PKT_SIZE: reg_rdata_o <= 32'(bpp_ff);
        REG_PKT_PER_FRAME: reg_rdata_o <= 32'(ppf_ff);
        REG_MIN_PERIOD: reg_rdata_o <= limit_ff;
        REG_STATUS: reg_rdata_o <= {26'h000_0000, pending_ff,
                                    dirty_ff || div_busy,
                                    xfer_period_ff > exp_period_ff,
                                    tx_ff != TX_IDLE,
                                    buf_ff == BUF_FULL,
                                    buf_ff == BUF_FILL};
        default: reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_frame_done;
    buf_ff == BUF_FILL && pix_i.valid && pix_i.last;
  endsequence
  sequence s_tx_armed;
    ##1 buf_ff == BUF_FULL ##1 tx_ff == TX_WAIT;
  endsequence

  property p_bpp_range;
    bpp_ff >= BPP_MIN && bpp_ff <= BPP_MAX;
  endproperty
  a_bpp_range: assert property (p_bpp_range)
    else $error("payload size outside 4..8192");

  // settings seen one edge back: a write may land on the checking edge
  property p_exp_period;
    $stable(exposure_ff) && $stable(height_ff) |=>
      exp_period_ff == 32'($past(exposure_ff))
        + 32'($past(height_ff)) * T_LINE_US + T_FIXED_US;
  endproperty
  a_exp_period: assert property (p_exp_period)
    else $error("exposure period mismatch");

  property p_start_elapsed;
    capture_start_o |-> $past(since_ff) >= $past(limit_ff)
      && $past(limit_ff) >= $past(exp_period_ff)
      && $past(limit_ff) >= $past(xfer_period_ff);
  endproperty
  a_start_elapsed: assert property (p_start_elapsed)
    else $error("capture started before minimum period");

  property p_frame_then_tx;
    s_frame_done |-> s_tx_armed;
  endproperty
  a_frame_then_tx: assert property (p_frame_then_tx)
    else $error("frame end did not arm packetizer");

  property p_no_tx_early;
    pkt_o.valid |-> $past(buf_ff) == BUF_FULL;
  endproperty
  a_no_tx_early: assert property (p_no_tx_early)
    else $error("packet data sent before frame complete");

  property p_eop_len;
    pkt_o.eop |-> $past(beat_ff) == tx_bpp_ff - 14'h0001;
  endproperty
  a_eop_len: assert property (p_eop_len)
    else $error("packet length differs from payload size");

  property p_sop_on_cycle;
    pkt_o.sop |-> $past(cyc_tick_ff, 2);
  endproperty
  a_sop_on_cycle: assert property (p_sop_on_cycle)
    else $error("packet not aligned to bus cycle");

  // a result finishing while dirty is stale and gets recomputed anyway
  property p_ppf_covers;
    div_done && !dirty_ff |=> 32'(ppf_ff) * 32'($past(bpp_ff))
      >= 32'($past(width_ff)) * 32'($past(height_ff));
  endproperty
  a_ppf_covers: assert property (p_ppf_covers)
    else $error("packets per frame too small");

  property p_color;
    buf_ff == BUF_FILL && !row_odd_ff && !col_ff[0] |->
      pix_color == COLOR_BLUE;
  endproperty
  a_color: assert property (p_color)
    else $error("wrong colour tag at even row and column");
endmodule

// >>> test/bus_host_model.sv
`timescale 1ns/1ps
module bus_host_model
  import frame_limit_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // packet stream from the camera
  input wire frame_limit_pkg::pkt_beat_t pkt_i
);
  // host side takes every beat as it comes; the bus has no backpressure
  logic [7:0] data_q[$];
  logic [1:0] color_q[$];
  int len_q[$];
  time sop_q[$];
  int cur;

  always @(posedge clk_sys_i) begin
    if (!rst_i && pkt_i.valid === 1'b1) begin
      if (pkt_i.sop) begin
        sop_q.push_back($time);
        cur = 0;
      end
      data_q.push_back(pkt_i.data);
      color_q.push_back(pkt_i.color);
      cur++;
      if (pkt_i.eop) begin
        len_q.push_back(cur);
      end
    end
  end
endmodule

// >>> test/frame_rate_limit_packetizer_tb.sv
`timescale 1ns/1ps
module frame_rate_limit_packetizer_tb;
  import frame_limit_pkg::*;
  logic clk_sys_i, rst_i, reg_wr_i, reg_rd_i, capture_req_i, capture_start_o;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, rd_val;
  pix_beat_t pix_i;
  pkt_beat_t pkt_o;
  int n_fail, compares, i, e, h, w, b, n, hits;
  logic [7:0] exp_q[$];
  logic [7:0] d;
  time t_last;

  frame_rate_limit_packetizer dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .capture_req_i(capture_req_i), .capture_start_o(capture_start_o),
    .pix_i(pix_i), .pkt_o(pkt_o)
  );

  bus_host_model host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .pkt_i(pkt_o));

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task finish_test;
    $display("mismatches %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // a wait that ran out of its bound
  task timed_out;
    check(32'h0000_0000, 32'h0000_0001);
    finish_test();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    rd_val = reg_rdata_o;
  endtask

  // packets-per-frame recompute runs in the background after a write to height, width or packet size
  task automatic settle;
    int k;
    repeat (4) @(posedge clk_sys_i);
    for (k = 0; k < 200; k++) begin
      rd(REG_STATUS);
      if (rd_val[4] === 1'b0) break;
    end
    if (k == 200) timed_out();
  endtask

  function automatic int ppf_of(int wi, int hi, int bi);
    return (wi * hi + bi - 1) / bi;
  endfunction

  function automatic int per_of(int ei, int hi, int p);
    int x;
    int y;
    x = ei + hi * 31 + 397;
    y = p * 125;
    return (x > y) ? x : y;
  endfunction

  function automatic logic [1:0] color_of(int r, int c);
    if (r % 2 == 0 && c % 2 == 0) return COLOR_BLUE;
    if (r % 2 == 1 && c % 2 == 1) return COLOR_RED;
    return COLOR_GREEN;
  endfunction

  initial begin
    void'($urandom(72));
    rst_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0000_0000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    capture_req_i = 1'b0;
    pix_i = '0;
    n_fail = 0;
    compares = 0;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    check(32'(pkt_o), 32'h0000_0000);
    rd(REG_PKT_SIZE);
    check(rd_val, 32'(BPP_RST));
    rd(REG_EXPOSURE);
    check(rd_val, 32'(EXPOSURE_RST));
    rd(REG_AOI_HEIGHT);
    check(rd_val, 32'(AOI_HEIGHT_RST));
    rd(REG_CTRL);
    check(rd_val, 32'h0000_0000);
    settle();
    rd(REG_PKT_PER_FRAME);
    check(rd_val, 32'(ppf_of(64, 64, 8192)));
    rd(REG_MIN_PERIOD);
    check(rd_val, 32'(per_of(1000, 64, 1)));
    rd(8'h20);
    check(rd_val, 32'h0000_0000);
    // payload size edges: below and above the accepted span
    wr(REG_PKT_SIZE, 32'h0000_0002);
    rd(REG_PKT_SIZE);
    check(rd_val, 32'h0000_0004);
    wr(REG_PKT_SIZE, 32'h0000_3FFF);
    rd(REG_PKT_SIZE);
    check(rd_val, 32'h0000_2000);
    for (i = 0; i < 5; i++) begin
      e = $urandom % 5000;
      h = 1 + $urandom % 64;
      w = 1 + $urandom % 64;
      b = (i == 0) ? 4 : 4 + $urandom % 8189;
      wr(REG_EXPOSURE, 32'(e));
      wr(REG_AOI_HEIGHT, 32'(h));
      wr(REG_AOI_WIDTH, 32'(w));
      wr(REG_PKT_SIZE, 32'(b));
      settle();
      rd(REG_PKT_PER_FRAME);
      check(rd_val, 32'(ppf_of(w, h, b)));
      rd(REG_MIN_PERIOD);
      check(rd_val, 32'(per_of(e, h, ppf_of(w, h, b))));
    end
    // one 4x4 frame in two 8-byte packets
    wr(REG_AOI_WIDTH, 32'h0000_0004);
    wr(REG_AOI_HEIGHT, 32'h0000_0004);
    wr(REG_EXPOSURE, 32'h0000_000A);
    wr(REG_PKT_SIZE, 32'h0000_0008);
    wr(REG_CTRL, 32'h0000_0001);
    settle();
    @(posedge clk_sys_i);
    capture_req_i <= 1'b1;
    @(posedge clk_sys_i);
    capture_req_i <= 1'b0;
    for (n = 0; n < 100 && capture_start_o !== 1'b1; n++) begin
      @(posedge clk_sys_i);
      #1;
    end
    if (n == 100) timed_out();
    for (i = 0; i < 16; i++) begin
      d = (i == 0) ? 8'hFF : 8'($urandom);
      exp_q.push_back(d);
      @(posedge clk_sys_i);
      pix_i <= '{1'b1, (i == 15), d};
    end
    @(posedge clk_sys_i);
    pix_i <= '0;
    t_last = $time;
    for (n = 0; n < 60000 && host.len_q.size() < 2; n++)
      @(posedge clk_sys_i);
    if (n == 60000) timed_out();
    check(32'(host.len_q.size()), 32'h0000_0002);
    foreach (host.len_q[i]) check(32'(host.len_q[i]), 32'h0000_0008);
    for (i = 0; i < 16; i++) begin
      check(32'(host.data_q[i]), 32'(exp_q[i]));
      check(32'(host.color_q[i]), 32'(color_of(i / 4, i % 4)));
    end
    check(32'(host.sop_q[0] > t_last), 32'h0000_0001);
    check(32'(host.sop_q[1] - host.sop_q[0]), 32'h0001_E848);
    // a second request so soon must stay pending
    @(posedge clk_sys_i);
    capture_req_i <= 1'b1;
    @(posedge clk_sys_i);
    capture_req_i <= 1'b0;
    hits = 0;
    repeat (2000) begin
      @(posedge clk_sys_i);
      #1;
      if (capture_start_o !== 1'b0) hits++;
    end
    check(32'(hits), 32'h0000_0000);
    rd(REG_STATUS);
    check(32'(rd_val[5]), 32'h0000_0001);
    finish_test();
  end
endmodule
